//--- hdl/stp_regs.svh
// Offsets, field positions, prescaler width and tap bits of the shared timer prescaler
`ifndef STP_REGS_SVH
`define STP_REGS_SVH
`define STP_CTRL_IO_ADDR     8'h20
`define STP_CTRL_DATA_ADDR   8'h40
`define STP_CTRL_RESET       8'h00
`define STP_BIT_SYNC_HOLD    7
`define STP_BIT_T0_PSR       1
`define STP_BIT_SHARED_PSR   0
`define STP_PRESCALER_WIDTH  10
`define STP_DIV8_TAP         2
`define STP_DIV64_TAP        5
`define STP_DIV256_TAP       7
`define STP_DIV1024_TAP      9
`endif

//--- hdl/stp_pkg.sv
// Types shared by the shared timer prescaler files
package stp_pkg;
  typedef enum logic [2:0] {
    STP_CS_STOP    = 3'h0,
    STP_CS_DIRECT  = 3'h1,
    STP_CS_DIV8    = 3'h2,
    STP_CS_DIV64   = 3'h3,
    STP_CS_DIV256  = 3'h4,
    STP_CS_DIV1024 = 3'h5,
    STP_CS_EXT_NEG = 3'h6,
    STP_CS_EXT_POS = 3'h7
  } stp_clock_source_select_e;
  typedef logic [7:0] stp_byte_t;
endpackage

//--- hdl/stp_ext_edge.sv
// Synchroniser and edge detector for one external count pin
`timescale 1ns/1ps
`include "stp_regs.svh"
module stp_ext_edge
  import stp_pkg::*;
(
  input  wire logic                              ref_clk_i,
  input  wire logic                              rst_n_i,
  input  wire logic                              clk_en_i,
  input  wire logic                              external_count_pin_i,
  input  wire stp_pkg::stp_clock_source_select_e clock_source_select_i,
  output logic                                   ext_tick_o
);
  import stp_pkg::*;

  logic latch_q;
  logic sync_reg;
  logic prev_reg;

  // Latch open while the clock is high; modelled as a falling-edge capture
  always_ff @(negedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      latch_q <= 1'b0;
    else if (clk_en_i)
      latch_q <= external_count_pin_i;
  end

  // Rising-edge stages after the latch
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end
    else if (clk_en_i)
    begin
      sync_reg <= latch_q;
      prev_reg <= sync_reg;
    end
  end

  // One tick per edge, polarity from the select, no division
  always_comb
  begin
    case (clock_source_select_i)
      STP_CS_EXT_POS: ext_tick_o = sync_reg & ~prev_reg;
      STP_CS_EXT_NEG: ext_tick_o = ~sync_reg & prev_reg;
      default:        ext_tick_o = 1'b0;
    endcase
  end

  a_ext_pos_tick: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (clock_source_select_i == STP_CS_EXT_POS && ext_tick_o) |-> sync_reg && !prev_reg)
    else $error("rising tick without rising edge");
endmodule

//--- hdl/stp_prescaler.sv
// Shared prescaler, clock select for three timers and the control register
`timescale 1ns/1ps
`include "stp_regs.svh"
module stp_prescaler
  import stp_pkg::*;
#(
  parameter int TIMERS   = 3,
  parameter int PS_WIDTH = `STP_PRESCALER_WIDTH
)
(
  input  wire logic                     ref_clk_i,
  input  wire logic                     rst_n_i,
  input  wire logic                     clk_en_i,
  input  wire logic [7:0]               io_addr_i,
  input  wire logic                     io_data_space_i,
  input  wire logic                     io_wr_i,
  input  wire logic                     io_rd_i,
  input  wire stp_pkg::stp_byte_t       io_wdata_i,
  output stp_pkg::stp_byte_t            io_rdata_o,
  input  wire logic [3*TIMERS-1:0]      clock_source_select_i,
  input  wire logic [TIMERS-1:0]        external_count_pin_i,
  output logic [TIMERS-1:0]             timer_tick_o,
  output logic                          timer0_prescaler_reset_o
);
  import stp_pkg::*;

  logic                timer_sync_hold_reg;
  logic                shared_prescaler_reset_reg;
  logic                timer0_prescaler_reset_reg;
  logic [PS_WIDTH-1:0] prescaler_reg;
  logic [PS_WIDTH-1:0] prescaler_next;
  logic [3:0]          tap_pulse;
  logic                ctrl_hit;
  logic [TIMERS-1:0]   ext_tick;
  stp_byte_t           rdata_reg;

  // Decode both address views of the control register
  assign ctrl_hit = io_data_space_i ? (io_addr_i == `STP_CTRL_DATA_ADDR)
                                    : (io_addr_i == `STP_CTRL_IO_ADDR);

  // Sync hold bit
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      timer_sync_hold_reg <= 1'b0;
    else if (clk_en_i && io_wr_i && ctrl_hit)
      timer_sync_hold_reg <= io_wdata_i[`STP_BIT_SYNC_HOLD];
  end

  // Prescaler reset bits: kept while hold set, cleared by hardware otherwise
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      shared_prescaler_reset_reg <= 1'b0;
      timer0_prescaler_reset_reg <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (io_wr_i && ctrl_hit)
      begin
        // Written value stands only if hold is set by this same write
        shared_prescaler_reset_reg <= io_wdata_i[`STP_BIT_SHARED_PSR]
                                      & io_wdata_i[`STP_BIT_SYNC_HOLD];
        timer0_prescaler_reset_reg <= io_wdata_i[`STP_BIT_T0_PSR]
                                      & io_wdata_i[`STP_BIT_SYNC_HOLD];
      end
      else if (!timer_sync_hold_reg)
      begin
        shared_prescaler_reset_reg <= 1'b0;
        timer0_prescaler_reset_reg <= 1'b0;
      end
    end
  end

  assign timer0_prescaler_reset_o = timer0_prescaler_reset_reg;

  // Free-running counter, cleared by a write pulse or a held reset
  always_comb
  begin
    if ((io_wr_i && ctrl_hit && io_wdata_i[`STP_BIT_SHARED_PSR]) || shared_prescaler_reset_reg)
      prescaler_next = '0;
    else
      prescaler_next = prescaler_reg + 1'b1;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      prescaler_reg <= '0;
    else if (clk_en_i)
      prescaler_reg <= prescaler_next;
  end

  // Tap pulses when the low bits roll over
  assign tap_pulse[0] = &prescaler_reg[`STP_DIV8_TAP:0];
  assign tap_pulse[1] = &prescaler_reg[`STP_DIV64_TAP:0];
  assign tap_pulse[2] = &prescaler_reg[`STP_DIV256_TAP:0];
  assign tap_pulse[3] = &prescaler_reg[`STP_DIV1024_TAP:0];

  genvar g;
  generate
    for (g = 0; g < TIMERS; g++)
    begin : g_timer
      stp_clock_source_select_e sel;
      logic                     tick;
      assign sel = stp_clock_source_select_e'(clock_source_select_i[3*g +: 3]);

      stp_ext_edge u_ext (
        .ref_clk_i             (ref_clk_i),
        .rst_n_i               (rst_n_i),
        .clk_en_i              (clk_en_i),
        .external_count_pin_i  (external_count_pin_i[g]),
        .clock_source_select_i (sel),
        .ext_tick_o            (ext_tick[g])
      );

      // Clock select; held prescaler reset halts prescaled timers
      always_comb
      begin
        case (sel)
          STP_CS_STOP:    tick = 1'b0;
          STP_CS_DIRECT:  tick = clk_en_i;
          STP_CS_DIV8:    tick = clk_en_i & tap_pulse[0]
                                 & ~shared_prescaler_reset_reg;
          STP_CS_DIV64:   tick = clk_en_i & tap_pulse[1]
                                 & ~shared_prescaler_reset_reg;
          STP_CS_DIV256:  tick = clk_en_i & tap_pulse[2]
                                 & ~shared_prescaler_reset_reg;
          STP_CS_DIV1024: tick = clk_en_i & tap_pulse[3]
                                 & ~shared_prescaler_reset_reg;
          STP_CS_EXT_NEG,
          STP_CS_EXT_POS: tick = clk_en_i & ext_tick[g];
          default:        tick = 1'b0;
        endcase
      end

      // One driver per tick bit keeps the mux free of shared-variable writes
      assign timer_tick_o[g] = tick;

      a_stop_idle: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        sel == STP_CS_STOP |-> !timer_tick_o[g])
        else $error("tick while stopped");
      a_div8_rate: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (clk_en_i && sel == STP_CS_DIV8 && timer_tick_o[g])
          |-> prescaler_reg[2:0] == 3'h7)
        else $error("divide-by-8 tick at wrong phase");
      a_div1024_rate: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (sel == STP_CS_DIV1024 && timer_tick_o[g]) |-> prescaler_reg[9:0] == 10'h3ff)
        else $error("divide-by-1024 tick at wrong phase");
      a_direct_tick: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (clk_en_i && sel == STP_CS_DIRECT) |-> timer_tick_o[g])
        else $error("direct select missed a tick");
      a_held_no_tick: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (shared_prescaler_reset_reg && sel >= STP_CS_DIV8 && sel <= STP_CS_DIV1024)
          |-> !timer_tick_o[g])
        else $error("prescaled tick while reset held");
    end
  endgenerate

  // Read data registered
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_reg <= `STP_CTRL_RESET;
    else if (clk_en_i && io_rd_i)
      rdata_reg <= ctrl_hit ? {timer_sync_hold_reg, 5'h00,
                               timer0_prescaler_reset_reg, shared_prescaler_reset_reg}
                            : 8'h00;
  end

  assign io_rdata_o = rdata_reg;

  a_psr_self_clear: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (clk_en_i && !timer_sync_hold_reg && !(io_wr_i && ctrl_hit))
      |=> !shared_prescaler_reset_reg)
    else $error("prescaler reset not self-cleared");
  a_hold_keeps: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (clk_en_i && timer_sync_hold_reg && shared_prescaler_reset_reg && !io_wr_i)
      |=> shared_prescaler_reset_reg)
    else $error("held prescaler reset dropped");
  a_hold_release: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (clk_en_i && io_wr_i && ctrl_hit && !io_wdata_i[`STP_BIT_SYNC_HOLD])
      |=> !shared_prescaler_reset_reg && !timer0_prescaler_reset_reg)
    else $error("release did not clear reset bits");
  a_reset_restarts: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (clk_en_i && shared_prescaler_reset_reg) |=> prescaler_reg == '0)
    else $error("prescaler not restarted");
  a_free_run: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (clk_en_i && !shared_prescaler_reset_reg && !io_wr_i)
      |=> prescaler_reg == $past(prescaler_reg) + 1'b1)
    else $error("prescaler not free running");
  a_unmapped_read: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (clk_en_i && io_rd_i && !ctrl_hit) |=> io_rdata_o == 8'h00)
    else $error("unmapped read returned data");
endmodule

//--- bench/stp_pin_model.sv
// External count pin source with a fixed half period
`timescale 1ns/1ps
module stp_pin_model
#(
  parameter int HALF = 3
)
(
  input  wire logic ref_clk_i,
  input  wire logic run_i,
  output logic      pin_o
);
  int cnt_reg = 0;
  initial pin_o = 1'b0;
  // Toggles only while running, each half above one clock
  always @(posedge ref_clk_i)
  begin
    cnt_reg <= run_i ? (cnt_reg + 1) % HALF : 0;
    if (run_i && cnt_reg == HALF - 1)
      pin_o <= ~pin_o;
  end
endmodule

//--- bench/shared_timer_prescaler_tb_top.sv
// Self-checking bench for the shared timer prescaler
`timescale 1ns/1ps
module shared_timer_prescaler_tb_top;
  import stp_pkg::*;
  logic       ref_clk_i;
  logic       rst_n_i;
  logic       ds;
  logic       wr_en;
  logic       rd_en;
  logic       run;
  logic       pin;
  logic       t0_rst;
  logic [7:0] addr;
  stp_byte_t  wdata;
  stp_byte_t  rdata;
  logic [8:0] sel;
  logic [2:0] tick;
  int         error_cnt = 0;
  int         cmp_count = 0;

  stp_prescaler u_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1),
    .io_addr_i(addr), .io_data_space_i(ds), .io_wr_i(wr_en), .io_rd_i(rd_en),
    .io_wdata_i(wdata), .io_rdata_o(rdata), .clock_source_select_i(sel),
    .external_count_pin_i({3{pin}}), .timer_tick_o(tick),
    .timer0_prescaler_reset_o(t0_rst));
  stp_pin_model u_pin (.ref_clk_i(ref_clk_i), .run_i(run), .pin_o(pin));

  initial
  begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic d_s, input stp_byte_t d);
    @(posedge ref_clk_i);
    addr  <= a;
    ds    <= d_s;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk_i);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic d_s, input stp_byte_t exp);
    @(posedge ref_clk_i);
    addr  <= a;
    ds    <= d_s;
    rd_en <= 1'b1;
    @(posedge ref_clk_i);
    rd_en <= 1'b0;
    @(posedge ref_clk_i);
    #1 chk("control", 16'(exp), 16'(rdata));
  endtask

  // Counts ticks of every timer and notes the cycle of each first tick
  task automatic cnt(input int c, output int n[3], output int f[3]);
    n = '{0, 0, 0};
    f = '{0, 0, 0};
    for (int i = 1; i <= c; i++)
    begin
      @(negedge ref_clk_i);
      for (int g = 0; g < 3; g++)
      begin
        n[g] += int'(tick[g] === 1'b1);
        if (tick[g] === 1'b1 && f[g] == 0)
          f[g] = i;
      end
    end
  endtask

  task automatic t_regs;
    rd(8'h20, 1'b0, 8'h00);
    wr(8'h20, 1'b0, 8'h83);
    rd(8'h40, 1'b1, 8'h83);
    chk("t0_reset", 16'h1, 16'(t0_rst));
    wr(8'h40, 1'b1, 8'h00);
    rd(8'h20, 1'b0, 8'h00);
    chk("t0_reset", 16'h0, 16'(t0_rst));
    wr(8'h20, 1'b0, 8'h01);
    rd(8'h20, 1'b0, 8'h00);
    wr(8'h21, 1'b0, 8'hff);
    rd(8'h21, 1'b0, 8'h00);
    rd(8'h20, 1'b0, 8'h00);
  endtask

  task automatic t_taps;
    int n[3];
    int f[3];
    int sh[4] = '{3, 6, 8, 10};
    for (int k = 0; k < 4; k++)
    begin
      @(posedge ref_clk_i);
      sel <= {3'h0, 3'h1, 3'(k + 2)};
      @(posedge ref_clk_i);
      cnt(2048, n, f);
      chk("tap_ticks", 16'(2048 >> sh[k]), 16'(n[0]));
      chk("direct_ticks", 16'd2048, 16'(n[1]));
      chk("stopped_ticks", 16'd0, 16'(n[2]));
    end
  endtask

  task automatic t_restart(input bit hold);
    int n[3];
    int f[3];
    @(posedge ref_clk_i);
    sel <= {3'h5, 3'h3, 3'h2};
    repeat (37) @(posedge ref_clk_i);
    if (hold)
    begin
      wr(8'h20, 1'b0, 8'h81);
      cnt(300, n, f);
      chk("held_ticks", 16'd0, 16'(n[0] + n[1] + n[2]));
      wr(8'h20, 1'b0, 8'h00);
    end
    else
      wr(8'h20, 1'b0, 8'h01);
    cnt(1100, n, f);
    chk("first_div8", 16'h1, 16'(f[0] >= 1 && f[0] <= 9));
    chk("phase_div64", 16'd56, 16'(f[1] - f[0]));
    chk("phase_div1024", 16'd1016, 16'(f[2] - f[0]));
  endtask

  task automatic t_ext;
    int n[3];
    int m[3];
    int f[3];
    @(posedge ref_clk_i);
    sel <= {3'h6, 3'h0, 3'h7};
    repeat (3) @(posedge ref_clk_i);
    run <= 1'b1;
    cnt(30, n, f);
    @(posedge ref_clk_i);
    run <= 1'b0;
    cnt(6, m, f);
    chk("rise_ticks", 16'd5, 16'(n[0] + m[0]));
    chk("fall_ticks", 16'd5, 16'(n[2] + m[2]));
    chk("late_fall", 16'd1, 16'(m[2]));
    chk("idle_ticks", 16'd0, 16'(n[1] + m[1]));
  endtask

  task automatic print_verdict;
    $display("comparisons %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    #500us;
    error_cnt++;
    print_verdict();
  end

  initial
  begin
    {rst_n_i, ds, wr_en, rd_en, run, addr, wdata, sel} = '0;
    repeat (8) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    t_regs();
    t_taps();
    t_restart(1'b0);
    t_restart(1'b1);
    t_ext();
    print_verdict();
  end
endmodule
